// *** design/pvdp_port.v ***
// parallel video data port: general-purpose and 656 video sub-modes
// assumes port clock, frame syncs and data come from outside clk and run at most clk/2
`include "pvdp_consts.vh"
`default_nettype none

// Summary of operation
// - one clock, three syncs, sixteen data lines
// - general mode: one direction, up to 16 bits
// - video mode: one direction, 8 or 10 bits
// - recognise embedded line and field preambles
// - input mode: syncs and data are inputs
// - capture mode: drive syncs, sample data
// - capture mode: sync1 horizontal, sync2 vertical
// - output mode: drive data and 1-3 syncs
// - sync1 input triggers start of sampling
// - wait programmed port cycles after sync
// - read exactly count samples per trigger
// - width 8 or 10 through 16 bits
// - active mode drops blanking and vertical blanking
// - active mode removes control sequences
// - active mode: after field-1 sync wait for line start
// - active mode count means lines per frame
// - blanking mode passes only vertical blanking data
// - entire mode passes everything after sync
module pvdp_port (
    input  wire        clk,
    input  wire        resetn,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [15:0] regRdata,
    input  wire        portClockInput,
    input  wire [2:0]  frameSyncIn,
    output reg  [2:0]  frameSyncOut,
    output reg  [2:0]  frameSyncOe,
    input  wire [15:0] dataIn,
    output reg  [15:0] dataOut,
    output reg         dataOe,
    output reg  [15:0] rxData,
    output reg         rxValid,
    input  wire [15:0] txData,
    output reg         txTake
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ARM   = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_XFER  = 3'h3;
    localparam [2:0] ST_ITU   = 3'h4;

    reg  [15:0] portControl;
    reg  [15:0] syncDelay;
    reg  [15:0] sampleCount;
    reg  [2:0]  state;
    reg  [15:0] delayCnt;
    reg  [15:0] leftCnt;
    reg         vsyncPending;
    reg  [2:0]  pclkSync;
    reg  [2:0]  fsMeta;
    reg  [2:0]  fsSync;
    reg         fs1Prev;
    reg  [15:0] dataMeta;
    reg  [15:0] dataSync;
    reg  [1:0]  preStep;
    reg         fieldF;
    reg         vFlag;
    reg         inActive;
    reg         synced;
    reg         linesDone;
    reg  [15:0] lineCnt;
    wire [15:0] widthMask;
    wire [4:0]  widthBits;
    wire        enable;
    wire [1:0]  gpMode;
    wire [1:0]  ituMode;
    wire        ituSel;
    wire        ituOut;
    wire [1:0]  fsNum;
    wire        portRise;
    wire        fs1Rise;
    wire [15:0] sample;
    wire [7:0]  w8;
    wire        isXY;
    wire        isCtrl;
    wire        fieldStart;
    wire [2:0]  outFsMask;
    reg         keep;

    assign enable   = portControl[`PVDP_C_EN];
    assign gpMode   = portControl[`PVDP_C_MODE_HI:`PVDP_C_MODE_LO];
    assign ituSel   = portControl[`PVDP_C_ITU];
    assign ituMode  = portControl[`PVDP_C_ITUM_HI:`PVDP_C_ITUM_LO];
    assign ituOut   = portControl[`PVDP_C_ITUOUT];
    assign fsNum    = portControl[`PVDP_C_FSN_HI:`PVDP_C_FSN_LO];

    assign widthBits = (portControl[`PVDP_C_WID_HI:`PVDP_C_WID_LO] == 3'h0) ?
                       {1'b0, `PVDP_W8_BITS} : {1'b0, `PVDP_WID_BASE} +
                       {2'b00, portControl[`PVDP_C_WID_HI:`PVDP_C_WID_LO]};
    genvar gi;
    generate
        for (gi = 0; gi < `PVDP_DW; gi = gi + 1) begin : gMask
            assign widthMask[gi] = (gi < widthBits);
        end
    endgenerate

    // the port clock is only sampled; its rising edges pace all transfers
    // detection of edges needs the port clock at most half of clk
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pclkSync <= 3'h0;
            fsMeta   <= 3'h0;
            fsSync   <= 3'h0;
            dataMeta <= 16'h0000;
            dataSync <= 16'h0000;
        end else begin
            pclkSync <= {pclkSync[1:0], portClockInput};
            fsMeta   <= frameSyncIn;
            fsSync   <= fsMeta;
            dataMeta <= dataIn;
            dataSync <= dataMeta;
        end
    end
    assign portRise = pclkSync[1] & ~pclkSync[2];
    assign fs1Rise  = fsSync[0] & ~fs1Prev;
    assign sample   = dataSync & widthMask;

    // 10-bit video uses its top eight bits for code matching
    assign w8 = (widthBits == {1'b0, `PVDP_W8_BITS}) ? dataSync[7:0] : dataSync[9:2];
    assign isXY   = (preStep == 2'h3);
    // preamble words never appear inside active video
    assign isCtrl = isXY | (w8 == `PVDP_CODE_HI) | (w8 == `PVDP_CODE_LO);
    assign fieldStart = isXY & ~w8[`PVDP_XY_F] & w8[`PVDP_XY_V] & (fieldF | ~synced);

    // syncs used in output mode, one to three
    assign outFsMask = (fsNum == 2'h3) ? 3'h7 : (fsNum == 2'h2) ? 3'h3 : 3'h1;

    always @* begin
        case (ituMode)
            // nothing before a line start after sync
            `PVDP_ITU_ACT: keep = synced & inActive & ~isCtrl & ~linesDone;
            `PVDP_ITU_VBI: keep = synced & vFlag & ~isCtrl;
            `PVDP_ITU_ALL: keep = synced;
            default:       keep = 1'b0;
        endcase
    end

    // register port, read data valid only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portControl <= `PVDP_CTRL_RST;
            syncDelay   <= `PVDP_DELAY_RST;
            sampleCount <= `PVDP_COUNT_RST;
            regRdata    <= 16'h0000;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `PVDP_ADDR_CTRL:  portControl <= regWdata & `PVDP_CTRL_MASK;
                    `PVDP_ADDR_DELAY: syncDelay   <= regWdata;
                    `PVDP_ADDR_COUNT: sampleCount <= regWdata;
                    default:          portControl <= portControl;
                endcase
            end
            if (regRead) begin
                case (regAddr)
                    `PVDP_ADDR_CTRL:   regRdata <= portControl;
                    `PVDP_ADDR_DELAY:  regRdata <= syncDelay;
                    `PVDP_ADDR_COUNT:  regRdata <= sampleCount;
                    `PVDP_ADDR_STATUS: regRdata <= {lineCnt[7:0], linesDone, inActive,
                                                    vFlag, fieldF, synced, state};
                    default:           regRdata <= 16'h0000;
                endcase
            end else begin
                regRdata <= 16'h0000;
            end
        end
    end

    // port sequencer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state        <= ST_IDLE;
            delayCnt     <= 16'h0000;
            leftCnt      <= 16'h0000;
            vsyncPending <= 1'b0;
            fs1Prev      <= 1'b0;
            frameSyncOut <= 3'h0;
            frameSyncOe  <= 3'h0;
            dataOut      <= 16'h0000;
            dataOe       <= 1'b0;
            rxData       <= 16'h0000;
            rxValid      <= 1'b0;
            txTake       <= 1'b0;
            preStep      <= 2'h0;
            fieldF       <= 1'b0;
            vFlag        <= 1'b0;
            inActive     <= 1'b0;
            synced       <= 1'b0;
            linesDone    <= 1'b0;
            lineCnt      <= 16'h0000;
        end else begin
            rxValid <= 1'b0;
            txTake  <= 1'b0;
            if (portRise) begin
                fs1Prev <= fsSync[0];
            end
            if (!enable) begin
                state        <= ST_IDLE;
                vsyncPending <= 1'b1;
                frameSyncOut <= 3'h0;
                frameSyncOe  <= 3'h0;
                dataOe       <= 1'b0;
                synced       <= 1'b0;
                inActive     <= 1'b0;
                linesDone    <= 1'b0;
                preStep      <= 2'h0;
            end else begin
                // one direction at a time, chosen by the sub-mode
                if (ituSel) begin
                    frameSyncOe <= 3'h0;
                    dataOe      <= ituOut;
                end else begin
                    case (gpMode)
                        `PVDP_GP_CAPT: frameSyncOe <= 3'h3;
                        `PVDP_GP_OUT:  frameSyncOe <= outFsMask;
                        default:       frameSyncOe <= 3'h0;
                    endcase
                    dataOe <= (gpMode == `PVDP_GP_OUT);
                end
                if (portRise) begin
                    frameSyncOut <= 3'h0;
                    case (state)
                        ST_IDLE: begin
                            if (ituSel) begin
                                state <= ST_ITU;
                            end else if (gpMode == `PVDP_GP_IN) begin
                                state <= ST_ARM;
                            end else begin
                                // output syncs pulse for one port cycle
                                if (gpMode == `PVDP_GP_OUT) begin
                                    frameSyncOut <= outFsMask;
                                end else begin
                                    frameSyncOut <= {1'b0, vsyncPending, 1'b1};
                                end
                                vsyncPending <= 1'b0;
                                delayCnt     <= syncDelay;
                                leftCnt      <= sampleCount;
                                state        <= ST_DELAY;
                            end
                        end
                        ST_ARM: begin
                            // sync1 rising edge starts a burst
                            if (fs1Rise) begin
                                delayCnt <= syncDelay;
                                leftCnt  <= sampleCount;
                                state    <= ST_DELAY;
                            end
                        end
                        ST_DELAY, ST_XFER: begin
                            // programmed port cycles before first sample
                            if (delayCnt != 16'h0000) begin
                                delayCnt <= delayCnt - 16'h0001;
                            end else if (leftCnt == 16'h0000) begin
                                state <= ST_IDLE;
                            end else begin
                                if (gpMode == `PVDP_GP_OUT) begin
                                    dataOut <= txData & widthMask;
                                    txTake  <= 1'b1;
                                end else begin
                                    // one word per sample, in order
                                    rxData  <= sample;
                                    rxValid <= 1'b1;
                                end
                                // exactly the programmed number of samples
                                leftCnt <= leftCnt - 16'h0001;
                                state   <= (leftCnt == 16'h0001) ? ST_IDLE : ST_XFER;
                            end
                        end
                        ST_ITU: begin
                            if (ituOut) begin
                                dataOut <= txData & widthMask;
                                txTake  <= 1'b1;
                            end else begin
                                // preamble tracker: one high code word, two low code words, then flags
                                case (preStep)
                                    2'h0: preStep <= (w8 == `PVDP_CODE_HI) ? 2'h1 : 2'h0;
                                    2'h1: preStep <= (w8 == `PVDP_CODE_LO) ? 2'h2 :
                                                     (w8 == `PVDP_CODE_HI) ? 2'h1 : 2'h0;
                                    2'h2: preStep <= (w8 == `PVDP_CODE_LO) ? 2'h3 :
                                                     (w8 == `PVDP_CODE_HI) ? 2'h1 : 2'h0;
                                    default: preStep <= 2'h0;
                                endcase
                                if (keep) begin
                                    rxData  <= sample;
                                    rxValid <= 1'b1;
                                end
                                if (isXY) begin
                                    fieldF <= w8[`PVDP_XY_F];
                                    vFlag  <= w8[`PVDP_XY_V];
                                    if (fieldStart) begin
                                        synced    <= 1'b1;
                                        lineCnt   <= 16'h0000;
                                        linesDone <= 1'b0;
                                        inActive  <= 1'b0;
                                    end else if (!w8[`PVDP_XY_H] && !w8[`PVDP_XY_V]) begin
                                        inActive <= synced;
                                    end else if (w8[`PVDP_XY_H]) begin
                                        inActive <= 1'b0;
                                        // count closes after that many lines
                                        if (inActive && !linesDone) begin
                                            lineCnt <= lineCnt + 16'h0001;
                                            if (lineCnt + 16'h0001 == sampleCount) begin
                                                linesDone <= 1'b1;
                                            end
                                        end
                                    end
                                end
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** shared/pvdp_consts.vh ***
// constants for the parallel video data port: register map, control fields, codes
// assumes a 4-bit byte address and a 16-bit register data path
`ifndef PVDP_CONSTS_VH
`define PVDP_CONSTS_VH

`define PVDP_AW           4
`define PVDP_DW           16
`define PVDP_ADDR_CTRL    4'h0
`define PVDP_ADDR_DELAY   4'h4
`define PVDP_ADDR_COUNT   4'h8
`define PVDP_ADDR_STATUS  4'hC

// control register fields
`define PVDP_C_EN         0
`define PVDP_C_MODE_HI    2
`define PVDP_C_MODE_LO    1
`define PVDP_C_ITU        3
`define PVDP_C_ITUM_HI    5
`define PVDP_C_ITUM_LO    4
`define PVDP_C_ITUOUT     6
`define PVDP_C_WID_HI     9
`define PVDP_C_WID_LO     7
`define PVDP_C_FSN_HI     11
`define PVDP_C_FSN_LO     10
`define PVDP_CTRL_MASK    16'h0FFF
`define PVDP_CTRL_RST     16'h0000
`define PVDP_DELAY_RST    16'h0000
`define PVDP_COUNT_RST    16'h0000

// general-purpose sub-modes
`define PVDP_GP_IN        2'h0
`define PVDP_GP_CAPT      2'h1
`define PVDP_GP_OUT       2'h2
// video sub-modes
`define PVDP_ITU_ACT      2'h0
`define PVDP_ITU_VBI      2'h1
`define PVDP_ITU_ALL      2'h2

// embedded preamble codes, upper eight bits of a sample
`define PVDP_CODE_HI      8'hFF
`define PVDP_CODE_LO      8'h00
`define PVDP_XY_F         6
`define PVDP_XY_V         5
`define PVDP_XY_H         4
`define PVDP_W8_BITS      4'h8
`define PVDP_WID_BASE     4'h9

`endif

// *** sim/pvdp_port_props.sv ***
// assertions on the video port pins and its register port
// assumes the control register changes only through register port writes
`include "pvdp_consts.vh"
`default_nettype none
module pvdp_port_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdata,
    input wire logic [2:0]  frameSyncOe,
    input wire logic        dataOe,
    input wire logic [15:0] rxData,
    input wire logic        rxValid,
    input wire logic        txTake
);
    logic [15:0] ctrl;
    logic [1:0]  age;
    wire  [2:0]  wid = ctrl[`PVDP_C_WID_HI:`PVDP_C_WID_LO];
    wire  [1:0]  fsn = ctrl[`PVDP_C_FSN_HI:`PVDP_C_FSN_LO];
    wire  [1:0]  md = ctrl[`PVDP_C_MODE_HI:`PVDP_C_MODE_LO];
    wire         on = age == 2'h3 && ctrl[`PVDP_C_EN];
    wire         gp = on && !ctrl[`PVDP_C_ITU];
    wire  [15:0] wmask = (wid == 3'h0) ? 16'h00FF : 16'hFFFF >> (3'h7 - wid);
    wire  [2:0]  fsWant = (fsn == 2'h3) ? 3'h7 : (fsn == 2'h2) ? 3'h3 : 3'h1;
    // outputs are registered behind the control register, so judge them once settled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `PVDP_CTRL_RST;
            age <= 2'h0;
        end else if (regWrite && regAddr == `PVDP_ADDR_CTRL) begin
            ctrl <= regWdata & `PVDP_CTRL_MASK;
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_ctrl_readback: assert property (regRead && regAddr == `PVDP_ADDR_CTRL
        |=> regRdata == $past(ctrl)) else $error("control read back wrong");
    a_idle_quiet: assert property (age == 2'h3 && !ctrl[`PVDP_C_EN]
        |-> !rxValid && !dataOe && frameSyncOe == 3'h0) else $error("disabled port active");
    a_input_listen: assert property (gp && md == `PVDP_GP_IN
        |-> frameSyncOe == 3'h0 && !dataOe) else $error("input mode drives pins");
    a_capture_dir: assert property (gp && md == `PVDP_GP_CAPT
        |-> frameSyncOe[1:0] == 2'h3 && !dataOe) else $error("capture pin direction wrong");
    a_output_dir: assert property (gp && md == `PVDP_GP_OUT
        |-> dataOe && frameSyncOe == fsWant) else $error("output pin direction wrong");
    a_one_dir: assert property (rxValid |-> !dataOe)
        else $error("receiving while driving data");
    a_rx_pulse: assert property (rxValid |=> !rxValid)
        else $error("two samples in adjacent cycles");
    a_rx_width: assert property (rxValid && on |-> (rxData & ~wmask) == 16'h0000)
        else $error("sample wider than selected width");
    a_no_ctrl_word: assert property (rxValid && on && ctrl[`PVDP_C_ITU] && wid == 3'h0
        && ctrl[`PVDP_C_ITUM_HI:`PVDP_C_ITUM_LO] == `PVDP_ITU_ACT
        |-> rxData[7:0] != 8'hFF && rxData[7:0] != 8'h00) else $error("control word passed");
    cover property (rxValid && gp);
    cover property (rxValid && ctrl[`PVDP_C_ITU]);
    cover property (txTake);
endmodule
bind pvdp_port pvdp_port_props u_props (
    .clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .frameSyncOe, .dataOe, .rxData, .rxValid, .txTake
);
`default_nettype wire

// *** sim/pvdp_source_model.sv ***
// external converter or video source that paces the port with its own clock
// assumes one caller at a time; the clock stands still between frames
`default_nettype none
module pvdp_source_model (
    output var logic        portClock,
    output var logic [2:0]  syncOut,
    output var logic [15:0] dataOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow;
    initial begin
        portClock = 1'b0;
        syncOut = 3'h0;
        dataOut = 16'h0000;
        slow = 1'b0;
    end
    // one word per 320 ns period, 640 ns when slow
    task automatic put(input logic [15:0] d, input logic s);
        dataOut = d;
        syncOut[0] = s;
        #(slow ? 480 : 160) portClock = 1'b1;
        #160 portClock = 1'b0;
    endtask
    // released lines show inverted data so a stale word never matches
    task automatic rest();
        syncOut = 3'h0;
        dataOut = ~dataOut;
    endtask
endmodule
`default_nettype wire

// *** sim/tb_pvdp_port.sv ***
// self-checking bench for the parallel video data port
// assumes a 25 MHz system clock and the source model pacing the port
`include "pvdp_consts.vh"
`default_nettype none
module tb_pvdp_port;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [15:0] ctrl;
        logic [15:0] dly;
        logic [15:0] cnt;
        logic [15:0] base;
        logic        slow;
        int          st;
        int          n;
    } pvdp_row_t;
    logic        clk, resetn, regWrite, regRead, dataOe, rxValid, txTake, srcClk;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, dutData, srcData, rxData, txData, v, exp;
    logic [2:0]  fsOut, fsOe, srcSync, fsSeen;
    logic [15:0] rxQ[$];
    int          numErrors = 0;
    int          nCompared = 0;
    int          txCount = 0;
    wire  [15:0] dataWire = dataOe ? dutData : srcData;
    wire  [2:0]  fsWire = (fsOe & fsOut) | (~fsOe & srcSync);
    logic [15:0] vid [17] = '{16'h00FF, 16'h0000, 16'h0000, 16'h0020, 16'h0010,
        16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h0055, 16'h0066,
        16'h00FF, 16'h0000, 16'h0000, 16'h0010, 16'h0077, 16'h0088};
    pvdp_row_t rows [8] = '{
        '{16'h0001, 16'h0000, 16'h0003, 16'hA5F0, 1'b0, 0, 3},
        '{16'h0081, 16'h0002, 16'h0004, 16'hFC10, 1'b0, 0, 4},
        '{16'h0381, 16'h0001, 16'h0001, 16'h8001, 1'b1, 0, 1},
        '{16'h0201, 16'h0003, 16'h0002, 16'h7777, 1'b0, 0, 2},
        '{16'h0001, 16'h0000, 16'h0000, 16'h1234, 1'b0, 0, 0},
        '{16'h0009, 16'h0000, 16'h0001, 16'h0000, 1'b0, 9, 2},
        '{16'h0019, 16'h0000, 16'h0001, 16'h0000, 1'b0, 4, 1},
        '{16'h0029, 16'h0000, 16'h0001, 16'h0000, 1'b0, 4, 13}};
    pvdp_port u_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .portClockInput(srcClk), .frameSyncIn(fsWire), .frameSyncOut(fsOut),
        .frameSyncOe(fsOe), .dataIn(dataWire), .dataOut(dutData), .dataOe(dataOe),
        .rxData(rxData), .rxValid(rxValid), .txData(txData), .txTake(txTake));
    pvdp_source_model u_src (.portClock(srcClk), .syncOut(srcSync), .dataOut(srcData));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rxValid === 1'b1) rxQ.push_back(rxData);
        if (txTake === 1'b1) txCount++;
        fsSeen |= fsOut;
    end
    function automatic logic [15:0] wmask(input logic [2:0] w);
        return (w == 3'h0) ? 16'h00FF : 16'hFFFF >> (3'h7 - w);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        nCompared++;
        if (seen !== want) begin
            numErrors++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk) regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk) regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk) regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic stopTest();
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        numErrors++;
        stopTest();
    end
    initial begin
        {resetn, regWrite, regRead, regAddr, regWdata} = '0;
        txData = 16'h00C3;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[r]) begin
            wr(`PVDP_ADDR_CTRL, 16'h0000);
            wr(`PVDP_ADDR_DELAY, rows[r].dly);
            wr(`PVDP_ADDR_COUNT, rows[r].cnt);
            wr(`PVDP_ADDR_CTRL, rows[r].ctrl);
            repeat (4) @(posedge clk);
            rxQ.delete();
            u_src.slow = rows[r].slow;
            #7;
            // the first port edge after enable only leaves idle, so lead with a filler word
            u_src.put(~rows[r].base, 1'b0);
            if (rows[r].ctrl[`PVDP_C_ITU]) begin
                foreach (vid[k]) u_src.put(vid[k], 1'b0);
            end else begin
                for (int k = 0; k < 8; k++) u_src.put(rows[r].base + 16'(k), k == 0);
            end
            u_src.rest();
            repeat (10) @(posedge clk);
            check("pins driven", {12'h0, fsOe, dataOe}, 16'h0000);
            check("rx count", 16'(rxQ.size()), 16'(rows[r].n));
            for (int i = 0; i < rows[r].n; i++) begin
                exp = rows[r].ctrl[`PVDP_C_ITU] ? vid[rows[r].st + i] : (rows[r].base
                    + rows[r].dly + 16'(1 + i)) & wmask(rows[r].ctrl[9:7]);
                check("rx word", rxQ[i], exp);
            end
        end
        // leave video mode through idle so the capture sequencer starts clean
        wr(`PVDP_ADDR_CTRL, 16'h0000);
        wr(`PVDP_ADDR_CTRL, 16'h0003);
        repeat (4) @(posedge clk);
        #7;
        rxQ.delete();
        fsSeen = 3'h0;
        repeat (4) u_src.put(16'h0042, 1'b0);
        check("capture pins", {12'h0, fsOe, dataOe}, 16'h0006);
        check("capture syncs", {13'h0, fsSeen}, 16'h0003);
        check("capture count", 16'(rxQ.size()), 16'h0002);
        check("capture word", rxQ[0], 16'h0042);
        wr(`PVDP_ADDR_CTRL, 16'h0C05);
        repeat (4) @(posedge clk);
        #7;
        fsSeen = 3'h0;
        repeat (4) u_src.put(16'h5A5A, 1'b0);
        u_src.rest();
        check("output pins", {12'h0, fsOe, dataOe}, 16'h000F);
        check("output syncs", {13'h0, fsSeen}, 16'h0007);
        check("data out", dutData, 16'h00C3);
        check("tx taken", 16'(txCount != 0), 16'h0001);
        wr(`PVDP_ADDR_CTRL, 16'h0049);
        repeat (4) @(posedge clk);
        #7;
        txCount = 0;
        repeat (3) u_src.put(16'h5A5A, 1'b0);
        u_src.rest();
        check("video out pins", {12'h0, fsOe, dataOe}, 16'h0001);
        check("video tx count", 16'(txCount), 16'h0002);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 16; a += 2) begin
            rd(4'(a), v);
            check("reg reset", v, 16'h0000);
        end
        wr(`PVDP_ADDR_CTRL, 16'hFFFE);
        wr(4'h2, 16'hFFFF);
        wr(`PVDP_ADDR_STATUS, 16'hFFFF);
        rd(`PVDP_ADDR_CTRL, v);
        check("ctrl readback", v, 16'h0FFE);
        rd(4'h2, v);
        check("unmapped read", v, 16'h0000);
        rd(`PVDP_ADDR_STATUS, v);
        check("status read only", v, 16'h0000);
        stopTest();
    end
endmodule
`default_nettype wire
